// ===== include/otd_pkg.sv
package otd_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int  CLK_PERIOD_NS   = 5;
    localparam int  BLANK_TIME_NS   = 200;   // Falling-edge blank time, plain default
    localparam int  BLANK_CYCLES    = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  BLANK_W         = 16;
    localparam logic [BLANK_W-1:0] BLANK_ZERO = 16'h0000;
    localparam logic [BLANK_W-1:0] BLANK_ONE  = 16'h0001;

    // ------------------------------------------------------------------
    // Diode-emulation states (numbers follow the state diagram)
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OTD_ST_BLANK = 2'b01,   // State one: switch off, blanking
        OTD_ST_WATCH = 2'b10,   // State two: switch off, watch drain voltage
        OTD_ST_COND  = 2'b11    // State three: switch on, watch drain current
    } otd_state_t;

    // ------------------------------------------------------------------
    // Power-up sequencing states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OTD_PU_WAIT  = 2'b00,   // Supply below rising threshold
        OTD_PU_BUILD = 2'b01,   // Rails building
        OTD_PU_READY = 2'b10    // Rails valid, fault released
    } otd_pwr_t;

    // Analog comparator flags grouped together
    typedef struct packed {
        logic supplyAboveRise;  // Supply above rising lockout threshold
        logic supplyBelowFall;  // Supply below falling lockout threshold
        logic fiveVoltGood;     // Internal five volt rail at threshold
        logic negRailGood;      // Negative gate rail at threshold
    } otd_supply_t;

    typedef struct packed {
        logic drainNegative;    // Negative drain voltage seen
        logic firstQuadrant;    // First-quadrant drain current seen
    } otd_sense_t;

endpackage : otd_pkg

// ===== verilog/otd_blank_timer.sv
`timescale 1ns/100ps
module otd_blank_timer #(
    parameter int COUNT_W  = otd_pkg::BLANK_W,
    parameter int TERMINAL = otd_pkg::BLANK_CYCLES
) (
    input  wire logic clk,      // Device clock
    input  wire logic rst,      // Synchronous reset, high
    input  wire logic restart,  // Restart on command falling edge
    output logic      expired   // Terminal count reached
);
    import otd_pkg::*;

    localparam logic [COUNT_W-1:0] TERM = COUNT_W'(TERMINAL);
    logic [COUNT_W-1:0] count;

    // ------------------------------------------------------------------
    // Counter restarts on every falling edge so back-to-back edges extend blanking
    // ------------------------------------------------------------------
    // Restart loads one, not zero: the restart cycle already counts as
    // blanked, so state one lasts exactly TERMINAL cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= TERM;
        end else if (restart) begin
            count <= BLANK_ONE[COUNT_W-1:0];    // [RULE13]
        end else if (count != TERM) begin
            count <= count + BLANK_ONE[COUNT_W-1:0];
        end
    end

    assign expired = (count == TERM) && !restart;

endmodule : otd_blank_timer

// ===== verilog/otd_diode_fsm.sv
`timescale 1ns/100ps
// Summary of operation
// [RULE1] Command falling edge in shutdown forces state one
// [RULE2] State one blanks fixed time, then state two
// [RULE3] State two off, negative drain goes three
// [RULE4] Shutdown entry starts machine in state two
// [RULE5] State three on, first-quadrant returns two
// [RULE6] Without edges, alternate only states two, three
// [RULE7] No counting or lockout of shoot-through events
// [RULE8] Controller should switch shutdown device first
// [RULE9] Fault output low during power-up
// [RULE10] Rails build only above rising threshold
// [RULE11] Falling threshold halts build until rising again
// [RULE12] Both rails good releases fault, follows command
// [RULE13] Blanking is parameterised restartable cycle counter
// [RULE14] Machine acts only in shutdown, else idle
module otd_diode_fsm #(
    parameter int BLANK_COUNT = otd_pkg::BLANK_CYCLES
) (
    input  wire logic                 clk,          // Device clock, 200 MHz
    input  wire logic                 rst,          // Synchronous reset, high
    input  wire logic                 switchCmd,    // Switch command from controller
    input  wire logic                 overtempShutdown, // Overtemp shutdown flag
    input  wire otd_pkg::otd_sense_t  sense,        // Drain comparators
    input  wire otd_pkg::otd_supply_t supply,       // Supply comparators
    output logic                      gateOn,       // Switch gate drive
    output logic                      faultN,       // Fault output, low active
    output logic                      railEnable,   // Build internal rails
    output otd_pkg::otd_state_t       diodeState    // Emulation state
);
    import otd_pkg::*;

    // ------------------------------------------------------------------
    // Command edge detect
    // ------------------------------------------------------------------
    logic     cmdPrev;
    logic     cmdFall;
    logic     blankDone;
    logic     otPrev;
    otd_pwr_t pwrState;
    otd_pwr_t next_pwrState;
    otd_state_t next_diodeState;
    logic     next_gateOn;

    // Previous command and shutdown levels for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            cmdPrev <= 1'b0;
            otPrev  <= 1'b0;
        end else begin
            cmdPrev <= switchCmd;
            otPrev  <= overtempShutdown;
        end
    end

    assign cmdFall = cmdPrev && !switchCmd;

    // Blank timer restarted by each command falling edge during overtemp shutdown
    otd_blank_timer #(
        .COUNT_W  (BLANK_W),
        .TERMINAL (BLANK_COUNT)
    ) otd_blank_timer_inst (
        .clk     (clk),
        .rst     (rst),
        .restart (cmdFall && overtempShutdown),
        .expired (blankDone)
    );

    // ------------------------------------------------------------------
    // Power-up sequencing
    // ------------------------------------------------------------------
    always_comb begin
        next_pwrState = pwrState;
        case (pwrState)
            OTD_PU_WAIT: begin
                if (supply.supplyAboveRise) begin
                    next_pwrState = OTD_PU_BUILD;   // [RULE10]
                end
            end
            OTD_PU_BUILD: begin
                if (supply.supplyBelowFall) begin
                    next_pwrState = OTD_PU_WAIT;    // [RULE11]
                end else if (supply.fiveVoltGood && supply.negRailGood) begin
                    next_pwrState = OTD_PU_READY;   // [RULE12]
                end
            end
            OTD_PU_READY: begin
                next_pwrState = OTD_PU_READY;
            end
            default: begin
                next_pwrState = OTD_PU_WAIT;
            end
        endcase
    end

    // Once ready the rails are kept; a later brownout is handled elsewhere
    always_ff @(posedge clk) begin
        if (rst) begin
            pwrState   <= OTD_PU_WAIT;
            faultN     <= 1'b0;     // [RULE9]
            railEnable <= 1'b0;
        end else begin
            pwrState   <= next_pwrState;
            faultN     <= (next_pwrState == OTD_PU_READY);   // [RULE9] [RULE12]
            railEnable <= (next_pwrState != OTD_PU_WAIT);    // [RULE10] [RULE11]
        end
    end

    // ------------------------------------------------------------------
    // Diode emulation state machine
    // ------------------------------------------------------------------
    always_comb begin
        next_diodeState = diodeState;
        if (!overtempShutdown || !otPrev) begin
            next_diodeState = OTD_ST_WATCH;     // [RULE4] [RULE14]
        end else if (cmdFall) begin
            next_diodeState = OTD_ST_BLANK;     // [RULE1]
        end else begin
            case (diodeState)
                OTD_ST_BLANK: begin
                    if (blankDone) begin
                        next_diodeState = OTD_ST_WATCH;   // [RULE2]
                    end
                end
                OTD_ST_WATCH: begin
                    if (sense.drainNegative) begin
                        next_diodeState = OTD_ST_COND;    // [RULE3] [RULE6]
                    end
                end
                OTD_ST_COND: begin
                    // Each detection just returns; no lockout, avoids third-quadrant loss
                    if (sense.firstQuadrant) begin
                        next_diodeState = OTD_ST_WATCH;   // [RULE5] [RULE7]
                    end
                end
                default: begin
                    next_diodeState = OTD_ST_WATCH;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            diodeState <= OTD_ST_WATCH;
        end else begin
            diodeState <= next_diodeState;
        end
    end

    // ------------------------------------------------------------------
    // Gate drive: command when normal, emulation when in shutdown
    // ------------------------------------------------------------------
    // Gated by the next power state so the gate is enabled on the same
    // edge that releases the fault output, never one cycle behind it
    always_comb begin
        if (next_pwrState != OTD_PU_READY) begin
            next_gateOn = 1'b0;                              // [RULE12]
        end else if (overtempShutdown) begin
            next_gateOn = (next_diodeState == OTD_ST_COND);  // [RULE1] [RULE3] [RULE5]
        end else begin
            next_gateOn = switchCmd;                         // [RULE14]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gateOn <= 1'b0;
        end else begin
            gateOn <= next_gateOn;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_fall_blank;
        @(posedge clk) disable iff (rst)
        (overtempShutdown && otPrev && cmdFall) |=> (diodeState == OTD_ST_BLANK) && !gateOn;
    endproperty
    a_fall_blank: assert property (p_fall_blank) else $error("no blank after fall"); // [RULE1]

    property p_blank_exit;
        @(posedge clk) disable iff (rst)
        (diodeState == OTD_ST_BLANK) && blankDone && overtempShutdown && !cmdFall
        |=> diodeState == OTD_ST_WATCH;
    endproperty
    a_blank_exit: assert property (p_blank_exit) else $error("blank stuck"); // [RULE2]

    property p_watch_off;
        @(posedge clk) disable iff (rst)
        overtempShutdown && $past(overtempShutdown) && (diodeState == OTD_ST_WATCH) |-> !gateOn;
    endproperty
    a_watch_off: assert property (p_watch_off) else $error("on in watch"); // [RULE3]

    property p_ot_entry;
        @(posedge clk) disable iff (rst)
        $rose(overtempShutdown) |=> diodeState == OTD_ST_WATCH;
    endproperty
    a_ot_entry: assert property (p_ot_entry) else $error("bad entry state"); // [RULE4]

    property p_cond_on;
        @(posedge clk) disable iff (rst)
        (diodeState == OTD_ST_COND) && overtempShutdown && faultN |-> gateOn;
    endproperty
    a_cond_on: assert property (p_cond_on) else $error("off in conduct"); // [RULE5]

    property p_retry;
        @(posedge clk) disable iff (rst)
        overtempShutdown && otPrev && !cmdFall && (diodeState == OTD_ST_COND)
        && sense.firstQuadrant |=> diodeState == OTD_ST_WATCH;
    endproperty
    a_retry: assert property (p_retry) else $error("no return to watch"); // [RULE7]

    property p_fault_low;
        @(posedge clk) disable iff (rst)
        (pwrState != OTD_PU_READY) |-> !faultN;
    endproperty
    a_fault_low: assert property (p_fault_low) else $error("fault released early"); // [RULE9]

    property p_halt;
        @(posedge clk) disable iff (rst)
        (pwrState == OTD_PU_BUILD) && supply.supplyBelowFall |=> !railEnable;
    endproperty
    a_halt: assert property (p_halt) else $error("build not halted"); // [RULE11]

    property p_release;
        @(posedge clk) disable iff (rst)
        (pwrState == OTD_PU_BUILD) && !supply.supplyBelowFall && supply.fiveVoltGood
        && supply.negRailGood |=> faultN ##1 faultN;
    endproperty
    a_release: assert property (p_release) else $error("fault not released"); // [RULE12]

    c_blank:   cover property (@(posedge clk) disable iff (rst)
        diodeState == OTD_ST_BLANK ##1 diodeState == OTD_ST_WATCH);
    c_diode:   cover property (@(posedge clk) disable iff (rst)
        diodeState == OTD_ST_WATCH ##1 diodeState == OTD_ST_COND ##[1:20] diodeState == OTD_ST_WATCH);
    c_ready:   cover property (@(posedge clk) disable iff (rst) $rose(faultN));

endmodule : otd_diode_fsm

// ===== testbench/otd_ctrl_model.sv
`timescale 1ns/100ps
module otd_ctrl_model (
    input  wire logic clk,       // Device clock
    input  wire logic rst,       // Synchronous reset, high
    input  wire logic onReq,     // Bench asks for switch on
    output logic      switchCmd  // Switch command to the device
);
    // Command retimed to the clock so every edge is a clean level change.
    // It keeps switching even while the fault output is low, as a stuck controller would.
    always_ff @(posedge clk) begin
        if (rst) begin
            switchCmd <= 1'b0;
        end else begin
            switchCmd <= onReq;  // Command follows onReq one clock later
        end
    end
endmodule : otd_ctrl_model

// ===== testbench/overtemp_ideal_diode_fsm_tb.sv
`timescale 1ns/100ps
module overtemp_ideal_diode_fsm_tb;
    import otd_pkg::*;
    localparam int BC = 4;  // Short blank count keeps the run brief
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            onReq = 1'b0;
    logic            otS = 1'b0;
    otd_sense_t      sen = '0;
    otd_supply_t     sup = '0;
    logic            switchCmd;
    logic            gateOn;
    logic            faultN;
    logic            railEnable;
    otd_state_t      diodeState;
    wire logic [4:0] outs = {gateOn, faultN, railEnable, diodeState};
    int              miscompares = 0;
    int              check_count = 0;
    int              n;

    // Clock, 5 ns period
    always #2.5 clk = ~clk;

    otd_ctrl_model otd_ctrl_model_inst (.clk(clk), .rst(rst), .onReq(onReq),
        .switchCmd(switchCmd));
    otd_diode_fsm #(.BLANK_COUNT(BC)) otd_diode_fsm_inst (.clk(clk), .rst(rst),
        .switchCmd(switchCmd), .overtempShutdown(otS), .sense(sen), .supply(sup),
        .gateOn(gateOn), .faultN(faultN), .railEnable(railEnable),
        .diodeState(diodeState));

    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick

    // Bounded wait on masked outputs; starts 1 ns late so edge updates have landed
    task automatic waitOut(input logic [4:0] m, input logic [4:0] v, input int lim);
        #1;
        n = 0;
        while (((outs & m) !== v) && n < lim) begin
            tick(1);
            n++;
        end
        chk(outs & m, v);
    endtask : waitOut

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // Watchdog at 3000 cycles, far beyond the sixty-odd cycles the tests need
    initial begin
        #(5 * 3000);
        miscompares++;
        give_verdict();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk(outs, 5'h02);
        tick(4);
        chk(outs & 5'h0c, 5'h00);
        $display("test reset done");
        @(posedge clk);
        sup <= 4'h8;
        waitOut(5'h0c, 5'h04, 4);
        @(posedge clk);
        sup <= 4'h4;
        waitOut(5'h04, 5'h00, 4);
        tick(4);
        chk(outs & 5'h0c, 5'h00);
        @(posedge clk);
        sup <= 4'h8;
        waitOut(5'h0c, 5'h04, 4);
        @(posedge clk);
        sup <= 4'ha;
        tick(4);
        chk(outs & 5'h08, 5'h00);
        @(posedge clk);
        sup <= 4'hb;
        waitOut(5'h08, 5'h08, 4);
        $display("test power-up done");
        @(posedge clk);
        onReq <= 1'b1;
        sen <= 2'h2;
        waitOut(5'h13, 5'h12, 4);
        tick(4);
        chk(outs & 5'h13, 5'h12);
        @(posedge clk);
        sen <= 2'h0;
        otS <= 1'b1;
        waitOut(5'h13, 5'h02, 3);
        @(posedge clk);
        onReq <= 1'b0;
        waitOut(5'h13, 5'h01, 4);
        waitOut(5'h03, 5'h02, 3 * BC);
        chk(5'(n), 5'(BC));
        $display("test blanking done");
        // Repeated shoot-through must never lock the switch out
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            sen <= 2'h2;
            waitOut(5'h13, 5'h13, 3);
            @(posedge clk);
            sen <= 2'h1;
            waitOut(5'h13, 5'h02, 3);
        end
        @(posedge clk);
        sen <= 2'h2;
        onReq <= 1'b1;
        waitOut(5'h13, 5'h13, 3);
        @(posedge clk);
        onReq <= 1'b0;
        waitOut(5'h13, 5'h01, 4);
        waitOut(5'h13, 5'h13, 3 * BC);
        $display("test emulation done");
        @(posedge clk);
        otS <= 1'b0;
        onReq <= 1'b1;
        waitOut(5'h13, 5'h12, 4);
        $display("test shutdown exit done");
        give_verdict();
    end
endmodule : overtemp_ideal_diode_fsm_tb
